// ### design/nfl_sequencer.sv
// NVM reload, fault recording and fault-log clear sequencer.
// Notes on behaviour
// RULE_01 - Reload trigger copies NVM configuration into SRAM.
// RULE_02 - Reload NACKs the host for two milliseconds.
// RULE_03 - Writing all-ones to conversion_record_enable enables recording.
// RULE_04 - Faults in continuous mode record temperatures and status.
// RULE_05 - Rewrite only on new fault with change or read.
// RULE_06 - NACK host accesses while recording a fault.
// RULE_07 - Writing zero to conversion_record_enable stops conversions and recording.
// RULE_08 - Fault-log clears act on two-byte words only.
// RULE_09 - Host zeroes data-in and targets channel MSB.
// RULE_10 - Clearing 0x8C resets both status bytes.
// RULE_11 - Writing 0x10 updates a word; control reads zero.
// RULE_12 - Host waits after programming alarm limits; the host model waits only after writing conversion_record_enable.
// RULE_13 - Open or shorted diode flagged and skipped.
// RULE_14 - Masked channels never assert either alarm.
// RULE_15 - Address band selects one of eight addresses.
// RULE_16 - After recording, alarm level tells fault state.
// RULE_17 - Host reads NVM data before RAM status.
// RULE_18 - Reload trigger clears itself when copy completes.
// RULE_19 - Log locations mirror SRAM registers 0x02 to primary_undertemp_status.
// RULE_20 - Counter-timed busy flag NACKs and clears control bits.
`timescale 1ns/1ps
`default_nettype none

module nfl_sequencer #(
    parameter int RELOAD_CYCLES = nfl_pkg::RELOAD_CYCLES,
    parameter int UPDATE_CYCLES = nfl_pkg::UPDATE_CYCLES,
    parameter int RECORD_CYCLES = nfl_pkg::RECORD_CYCLES
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_srst,
    input  wire nfl_pkg::nfl_access_type i_access,
    output logic                        o_nack,
    output logic [7:0]                  o_rdata,
    input  wire logic [2:0]             i_address_band,
    output logic [6:0]                  o_bus_address,
    input  wire logic                   i_continuous_mode,
    input  wire logic [15:0]            i_temperature [nfl_pkg::CHANNELS],
    input  wire logic [nfl_pkg::CHANNELS-1:0] i_over_fault,
    input  wire logic [nfl_pkg::CHANNELS-1:0] i_under_fault,
    input  wire logic [nfl_pkg::CHANNELS-1:0] i_secondary_fault,
    input  wire logic [nfl_pkg::CHANNELS-1:0] i_diode_open,
    input  wire logic [7:0]             i_nvm_config [8],
    output logic [7:0]                  o_sram_config [8],
    output logic [nfl_pkg::CHANNELS-1:0] o_channel_skip,
    output logic                        o_conversion_enable,
    output logic                        o_primary_alarm_n,
    output logic                        o_secondary_alarm_n
);

    // ------------------------------------------------------------------
    // Functions and storage
    // ------------------------------------------------------------------
    function automatic logic is_log_addr(input logic [7:0] a);
        return (a >= nfl_pkg::ADDR_LOG_FIRST) && (a <= nfl_pkg::ADDR_LOG_LAST);
    endfunction : is_log_addr

    function automatic logic [2:0] word_index(input logic [7:0] a);
        logic [7:0] off;
        off = a - nfl_pkg::ADDR_LOG_FIRST;
        return off[3:1];
    endfunction : word_index

    nfl_pkg::nfl_state_type state;
    logic [nfl_pkg::TIMER_WIDTH-1:0] timer;
    logic [7:0]  record_enable;
    logic [7:0]  control;
    logic [7:0]  target;
    logic [7:0]  data_high;
    logic [7:0]  data_low;
    logic [7:0]  alarm_mask;
    logic [15:0] log_word [nfl_pkg::LOG_WORDS];
    logic        recorded;
    logic        status_read;
    logic [15:0] live_status;
    logic [15:0] fault_now;
    logic [nfl_pkg::CHANNELS-1:0] over_sync1, over_sync2;
    logic [nfl_pkg::CHANNELS-1:0] under_sync1, under_sync2;
    logic [nfl_pkg::CHANNELS-1:0] sec_sync1, sec_sync2;
    logic [nfl_pkg::CHANNELS-1:0] open_sync1, open_sync2;
    logic        busy;
    logic        host_write;
    logic        new_fault;
    logic        want_record;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        over_sync1  <= i_over_fault;
        over_sync2  <= over_sync1;
        under_sync1 <= i_under_fault;
        under_sync2 <= under_sync1;
        sec_sync1   <= i_secondary_fault;
        sec_sync2   <= sec_sync1;
        open_sync1  <= i_diode_open;
        open_sync2  <= open_sync1;
    end

    // ------------------------------------------------------------------
    // Status, alarms and address
    // ------------------------------------------------------------------
    // Faulty diode channels carry no over or under flag of their own.
    assign o_channel_skip = open_sync2; // RULE_13
    assign fault_now = {3'h0, over_sync2 & ~open_sync2 & ~alarm_mask[4:0],
                        3'h0, under_sync2 & ~open_sync2 & ~alarm_mask[4:0]}; // RULE_14
    assign busy = (state != nfl_pkg::ST_IDLE); // RULE_20
    assign o_nack = busy; // RULE_02 RULE_06
    assign host_write = i_access.write && !busy;
    assign o_conversion_enable = (record_enable != nfl_pkg::RECORD_OFF_VALUE)
                                 && (state != nfl_pkg::ST_RECORD); // RULE_07
    assign new_fault = |fault_now;
    assign want_record = (record_enable == nfl_pkg::RECORD_ON_VALUE) && i_continuous_mode
                         && new_fault && (!recorded || (fault_now != live_status)
                         || status_read); // RULE_04 RULE_05

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_primary_alarm_n   <= 1'b1;
            o_secondary_alarm_n <= 1'b1;
        end else begin
            // After a record a low level means an unmasked over or under fault is present.
            o_primary_alarm_n   <= !new_fault; // RULE_14 RULE_16
            o_secondary_alarm_n <= !(|(sec_sync2 & ~open_sync2 & ~alarm_mask[4:0])); // RULE_14
        end
    end

    always_comb begin
        case (i_address_band) // RULE_15
            3'h0:    o_bus_address = 7'h1C;
            3'h1:    o_bus_address = 7'h1D;
            3'h2:    o_bus_address = 7'h1E;
            3'h3:    o_bus_address = 7'h1F;
            3'h4:    o_bus_address = 7'h4C;
            3'h5:    o_bus_address = 7'h4D;
            3'h6:    o_bus_address = 7'h4E;
            default: o_bus_address = 7'h4F;
        endcase
    end

    // ------------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            record_enable <= nfl_pkg::RESET_BYTE;
            target        <= nfl_pkg::RESET_BYTE;
            data_high     <= nfl_pkg::RESET_BYTE;
            data_low      <= nfl_pkg::RESET_BYTE;
            alarm_mask    <= nfl_pkg::RESET_MASK;
        end else if (host_write) begin
            case (i_access.addr)
                nfl_pkg::ADDR_RECORD_ENABLE: record_enable <= i_access.wdata; // RULE_03 RULE_07
                nfl_pkg::ADDR_NVM_TARGET:    target        <= i_access.wdata;
                nfl_pkg::ADDR_DATA_IN_HIGH:  data_high     <= i_access.wdata;
                nfl_pkg::ADDR_DATA_IN_LOW:   data_low      <= i_access.wdata;
                nfl_pkg::ADDR_ALARM_MASK:    alarm_mask    <= i_access.wdata;
                default: ;
            endcase
        end
    end

    // A status read arms a rewrite even if the fault pattern is unchanged.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            status_read <= 1'b0;
        end else if (i_access.read && !busy && ((i_access.addr == nfl_pkg::ADDR_OVER_STATUS)
                     || (i_access.addr == nfl_pkg::ADDR_UNDER_STATUS))) begin
            status_read <= 1'b1; // RULE_05
        end else if (state == nfl_pkg::ST_RECORD && timer == '0) begin
            status_read <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rdata <= nfl_pkg::RESET_BYTE;
        end else if (i_access.read && !busy) begin
            if (is_log_addr(i_access.addr)) begin
                o_rdata <= i_access.addr[0] ? log_word[word_index(i_access.addr)][7:0]
                                            : log_word[word_index(i_access.addr)][15:8];
            end else begin
                case (i_access.addr)
                    nfl_pkg::ADDR_OVER_STATUS:   o_rdata <= {3'h0, fault_now[12:8]};
                    nfl_pkg::ADDR_UNDER_STATUS:  o_rdata <= {3'h0, fault_now[4:0]};
                    nfl_pkg::ADDR_RECORD_ENABLE: o_rdata <= record_enable;
                    nfl_pkg::ADDR_NVM_CONTROL:   o_rdata <= control; // RULE_11
                    nfl_pkg::ADDR_NVM_TARGET:    o_rdata <= target;
                    nfl_pkg::ADDR_DATA_IN_HIGH:  o_rdata <= data_high;
                    nfl_pkg::ADDR_DATA_IN_LOW:   o_rdata <= data_low;
                    nfl_pkg::ADDR_ALARM_MASK:    o_rdata <= alarm_mask;
                    default:                     o_rdata <= nfl_pkg::RESET_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state   <= nfl_pkg::ST_IDLE;
            timer   <= '0;
            control <= nfl_pkg::RESET_BYTE;
        end else begin
            case (state)
                nfl_pkg::ST_IDLE: begin
                    if (host_write && i_access.addr == nfl_pkg::ADDR_NVM_CONTROL) begin
                        control <= i_access.wdata;
                        if (i_access.wdata[nfl_pkg::BIT_RELOAD_TRIGGER]) begin
                            state <= nfl_pkg::ST_RELOAD; // RULE_01
                            timer <= nfl_pkg::TIMER_WIDTH'(RELOAD_CYCLES - 1);
                        end else if (i_access.wdata[nfl_pkg::BIT_WORD_UPDATE]) begin
                            state <= nfl_pkg::ST_UPDATE; // RULE_11
                            timer <= nfl_pkg::TIMER_WIDTH'(UPDATE_CYCLES - 1);
                        end
                    end else if (want_record) begin
                        state <= nfl_pkg::ST_RECORD; // RULE_04
                        timer <= nfl_pkg::TIMER_WIDTH'(RECORD_CYCLES - 1);
                    end
                end
                nfl_pkg::ST_RELOAD, nfl_pkg::ST_UPDATE, nfl_pkg::ST_RECORD: begin
                    if (timer == '0) begin
                        state   <= nfl_pkg::ST_IDLE;
                        control <= nfl_pkg::RESET_BYTE; // RULE_18 RULE_20
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: state <= nfl_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration copy and fault log
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            for (int i = 0; i < 8; i++) o_sram_config[i] <= nfl_pkg::RESET_BYTE;
        end else if (state == nfl_pkg::ST_RELOAD && timer == '0) begin
            for (int i = 0; i < 8; i++) o_sram_config[i] <= i_nvm_config[i]; // RULE_01
        end
    end

    // The log lives in the NVM and so is left alone by the reset.
    always_ff @(posedge i_clock) begin
        if (state == nfl_pkg::ST_RECORD && timer == '0) begin
            for (int i = 0; i < nfl_pkg::CHANNELS; i++) begin
                if (!open_sync2[i]) log_word[i] <= i_temperature[i]; // RULE_19
            end
            log_word[nfl_pkg::LOG_WORDS-1] <= live_status; // RULE_19
        end else if (state == nfl_pkg::ST_UPDATE && timer == '0 && is_log_addr(target)) begin
            // Whole words only; the status word covers both status bytes.
            log_word[word_index(target)] <= {data_high, data_low}; // RULE_08 RULE_10
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            recorded    <= 1'b0;
            live_status <= 16'h0000;
        end else if (state == nfl_pkg::ST_IDLE && want_record) begin
            live_status <= fault_now;
        end else if (state == nfl_pkg::ST_RECORD && timer == '0) begin
            recorded <= 1'b1; // RULE_16
        end
    end

endmodule : nfl_sequencer
`default_nettype wire

// ### design/nfl_pkg.sv
// Package of constants and types for the NVM fault-log sequencer.
package nfl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TEMP_FIRST     = 8'h02;
    localparam logic [7:0] ADDR_OVER_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_UNDER_STATUS   = 8'h0D;
    localparam logic [7:0] ADDR_ALARM_MASK     = 8'h38;
    localparam logic [7:0] ADDR_RECORD_ENABLE  = 8'h39;
    localparam logic [7:0] ADDR_NVM_CONTROL    = 8'h3A;
    localparam logic [7:0] ADDR_NVM_TARGET     = 8'h3B;
    localparam logic [7:0] ADDR_DATA_IN_HIGH   = 8'h3C;
    localparam logic [7:0] ADDR_DATA_IN_LOW    = 8'h3D;
    localparam logic [7:0] ADDR_LOG_FIRST      = 8'h82;
    localparam logic [7:0] ADDR_LOG_LAST       = 8'h8D;
    localparam logic [7:0] ADDR_LOG_STATUS     = 8'h8C;
    localparam logic [7:0] NVM_OFFSET          = 8'h80;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int         BIT_RELOAD_TRIGGER  = 5;
    localparam int         BIT_WORD_UPDATE     = 4;
    localparam logic [7:0] RECORD_ON_VALUE     = 8'hFF;
    localparam logic [7:0] RECORD_OFF_VALUE    = 8'h00;
    localparam logic [7:0] RESET_BYTE          = 8'h00;
    localparam logic [7:0] RESET_MASK          = 8'h00;
    localparam int         LOG_WORDS           = 6;
    localparam int         CHANNELS            = 5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ       = 200;
    localparam int RELOAD_TIME_US  = 2000;
    localparam int UPDATE_TIME_US  = 25000;
    localparam int RECORD_TIME_US  = 20000;
    localparam int RELOAD_CYCLES   = RELOAD_TIME_US * CLOCK_MHZ;
    localparam int UPDATE_CYCLES   = UPDATE_TIME_US * CLOCK_MHZ;
    localparam int RECORD_CYCLES   = RECORD_TIME_US * CLOCK_MHZ;
    localparam int TIMER_WIDTH     = 24;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RELOAD = 4'b0010,
        ST_UPDATE = 4'b0100,
        ST_RECORD = 4'b1000
    } nfl_state_type;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nfl_access_type;

    typedef struct packed {
        logic [CHANNELS-1:0] over;
        logic [CHANNELS-1:0] under;
    } nfl_fault_type;

endpackage : nfl_pkg

// ### bench/nfl_host_model.sv
// Host controller model issuing one-cycle register accesses.
`timescale 1ns/1ps
`default_nettype none
module nfl_host_model #(
    parameter int SETTLE_CYCLES = 4
) (
    input  wire logic              i_clock,
    input  wire logic              i_nack,
    input  wire logic [7:0]        i_rdata,
    output var nfl_pkg::nfl_access_type o_access
);
    initial o_access = '0;
    // A real host retries after a refusal, so it waits for the busy window unless told to push.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                          input logic push, output logic [7:0] rdata);
        for (int n = 0; n < 200 && i_nack && !push; n++) begin
            @(posedge i_clock);
            #1;
        end
        o_access = '{write: wr, read: !wr, addr: addr, wdata: data};
        @(posedge i_clock);
        #1;
        o_access = '0;
        @(posedge i_clock);
        #1;
        rdata = i_rdata;
        if (wr && addr == nfl_pkg::ADDR_RECORD_ENABLE) begin
            repeat (SETTLE_CYCLES) @(posedge i_clock);
            #1;
        end
    endtask : access
endmodule : nfl_host_model
`default_nettype wire

// ### bench/nfl_sequencer_props.sv
// Concurrent checks on the sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module nfl_sequencer_props #(
    parameter int RELOAD_CYCLES = 12,
    parameter int UPDATE_CYCLES = 16,
    parameter int RECORD_CYCLES = 20
) (
    input wire logic                         i_clock,
    input wire logic                         i_srst,
    input wire nfl_pkg::nfl_access_type      i_access,
    input wire logic                         o_nack,
    input wire logic [2:0]                   i_address_band,
    input wire logic [6:0]                   o_bus_address,
    input wire logic [nfl_pkg::CHANNELS-1:0] i_diode_open,
    input wire logic [nfl_pkg::CHANNELS-1:0] o_channel_skip,
    input wire logic                         o_conversion_enable,
    input wire logic                         o_primary_alarm_n,
    input wire logic                         o_secondary_alarm_n
);
    localparam int LONG_A = RELOAD_CYCLES > UPDATE_CYCLES ? RELOAD_CYCLES : UPDATE_CYCLES;
    localparam int LONGEST = LONG_A > RECORD_CYCLES ? LONG_A : RECORD_CYCLES;
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    logic       taken_wr;
    logic       ctrl_wr;
    logic [7:0] rec_value;
    logic [3:0] masked_for;
    int         busy_count;
    assign taken_wr = i_access.write && !o_nack;
    assign ctrl_wr = taken_wr && i_access.addr == nfl_pkg::ADDR_NVM_CONTROL;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rec_value <= 8'h00;
        end else if (taken_wr && i_access.addr == nfl_pkg::ADDR_RECORD_ENABLE) begin
            rec_value <= i_access.wdata;
        end
    end
    // Counts settled cycles with every channel masked; any other mask write clears it to zero.
    always_ff @(posedge i_clock) begin
        if (i_srst || (taken_wr && i_access.addr == nfl_pkg::ADDR_ALARM_MASK
                       && i_access.wdata[4:0] != 5'h1F)) begin
            masked_for <= 4'h0;
        end else if (taken_wr && i_access.addr == nfl_pkg::ADDR_ALARM_MASK) begin
            masked_for <= 4'h1;
        end else if (masked_for != 4'h0 && masked_for != 4'hF) begin
            masked_for <= masked_for + 4'h1;
        end
    end
    always_ff @(posedge i_clock) begin
        busy_count <= (i_srst || !o_nack) ? 0 : busy_count + 1;
    end
    property p_address_table; o_bus_address == {i_address_band[2] ? 3'h4 : 3'h1, 2'h3, i_address_band[1:0]}; endproperty
    a_address_table: assert property (p_address_table) else $error("bus address off table");
    property p_reload_busy; ctrl_wr && i_access.wdata[5] |=> o_nack [*8]; endproperty
    a_reload_busy: assert property (p_reload_busy) else $error("reload not refusing");
    property p_update_busy; ctrl_wr && i_access.wdata == 8'h10 |=> o_nack [*8]; endproperty
    a_update_busy: assert property (p_update_busy) else $error("update not refusing");
    property p_busy_bound; o_nack |-> busy_count <= LONGEST; endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy window too long");
    property p_record_cause; $rose(o_nack) |-> $past(ctrl_wr) || $past(rec_value) == 8'hFF; endproperty
    a_record_cause: assert property (p_record_cause) else $error("busy without cause");
    property p_conversion_off; taken_wr && i_access.addr == 8'h39 && i_access.wdata == 8'h00 |=> !o_conversion_enable; endproperty
    a_conversion_off: assert property (p_conversion_off) else $error("conversion still on");
    property p_conversion_on; rec_value == 8'hFF && !o_nack |-> o_conversion_enable; endproperty
    a_conversion_on: assert property (p_conversion_on) else $error("conversion not on");
    property p_mask_quiet; masked_for == 4'hF |-> o_primary_alarm_n && o_secondary_alarm_n; endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("masked alarm active");
    property p_skip_follow; $stable(i_diode_open) [*4] |-> o_channel_skip == i_diode_open; endproperty
    a_skip_follow: assert property (p_skip_follow) else $error("skip flags lag");
endmodule : nfl_sequencer_props
bind nfl_sequencer nfl_sequencer_props #(
    .RELOAD_CYCLES(RELOAD_CYCLES), .UPDATE_CYCLES(UPDATE_CYCLES), .RECORD_CYCLES(RECORD_CYCLES)
) i_nfl_sequencer_props (
    .i_clock(i_clock), .i_srst(i_srst), .i_access(i_access), .o_nack(o_nack),
    .i_address_band(i_address_band), .o_bus_address(o_bus_address),
    .i_diode_open(i_diode_open), .o_channel_skip(o_channel_skip),
    .o_conversion_enable(o_conversion_enable), .o_primary_alarm_n(o_primary_alarm_n),
    .o_secondary_alarm_n(o_secondary_alarm_n)
);
`default_nettype wire

// ### bench/tb_nfl_sequencer.sv
// Self-checking bench for the NVM fault-log sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_nfl_sequencer;
    logic                         clock;
    logic                         srst;
    nfl_pkg::nfl_access_type      access;
    logic                         nack;
    logic [7:0]                   rdata;
    logic [2:0]                   band;
    logic [6:0]                   bus_address;
    logic [15:0]                  temperature [nfl_pkg::CHANNELS];
    logic [nfl_pkg::CHANNELS-1:0] over_fault;
    logic [nfl_pkg::CHANNELS-1:0] under_fault;
    logic [nfl_pkg::CHANNELS-1:0] sec_fault;
    logic                         cont_mode;
    logic [nfl_pkg::CHANNELS-1:0] diode_open;
    logic [nfl_pkg::CHANNELS-1:0] skip;
    logic [7:0]                   nvm_config [8];
    logic [7:0]                   sram_config [8];
    logic                         conversion;
    logic                         primary_alarm_n_n;
    logic                         secondary_alarm_n_n;
    logic [7:0]                   d;
    int                           failures;
    int                           total_checks;
    nfl_sequencer #(.RELOAD_CYCLES(12), .UPDATE_CYCLES(16), .RECORD_CYCLES(20)) i_nfl_sequencer (
        .i_clock(clock), .i_srst(srst), .i_access(access), .o_nack(nack), .o_rdata(rdata),
        .i_address_band(band), .o_bus_address(bus_address), .i_continuous_mode(cont_mode),
        .i_temperature(temperature), .i_over_fault(over_fault), .i_under_fault(under_fault),
        .i_secondary_fault(sec_fault), .i_diode_open(diode_open), .i_nvm_config(nvm_config),
        .o_sram_config(sram_config), .o_channel_skip(skip), .o_conversion_enable(conversion),
        .o_primary_alarm_n(primary_alarm_n_n), .o_secondary_alarm_n(secondary_alarm_n_n));
    nfl_host_model i_nfl_host_model (.i_clock(clock), .i_nack(nack), .i_rdata(rdata), .o_access(access));
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask : check_bit
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic push = 1'h0);
        logic [7:0] unused;
        i_nfl_host_model.access(1'h1, a, v, push, unused);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_nfl_host_model.access(1'h0, a, 8'h00, 1'h0, d);
    endtask : rd
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles
    task automatic t_address();
        for (int b = 0; b < 8; b++) begin
            band = 3'(b);
            cycles(1);
            check_byte({1'h0, bus_address}, b < 4 ? 8'h1C + 8'(b) : 8'h48 + 8'(b));
        end
    endtask : t_address
    task automatic t_reload();
        wr(nfl_pkg::ADDR_DATA_IN_LOW, 8'h11);
        wr(nfl_pkg::ADDR_NVM_CONTROL, 8'h20);
        check_bit(nack, 1'h1);
        wr(nfl_pkg::ADDR_DATA_IN_LOW, 8'h5A, 1'h1);
        rd(nfl_pkg::ADDR_NVM_CONTROL);
        check_byte(d, 8'h00);
        for (int k = 0; k < 8; k++) check_byte(sram_config[k], 8'hA0 + 8'(k));
        rd(nfl_pkg::ADDR_DATA_IN_LOW);
        check_byte(d, 8'h11);
    endtask : t_reload
    task automatic t_record();
        wr(nfl_pkg::ADDR_ALARM_MASK, 8'h1F);
        over_fault = 5'h02;
        cycles(20);
        check_bit(primary_alarm_n_n, 1'h1);
        wr(nfl_pkg::ADDR_ALARM_MASK, 8'h00);
        wr(nfl_pkg::ADDR_RECORD_ENABLE, 8'hFF);
        check_bit(nack, 1'h1);
        rd(nfl_pkg::ADDR_LOG_STATUS);
        check_byte(d, 8'h02);
        rd(8'h82);
        check_byte(d, 8'h20);
        check_bit(primary_alarm_n_n, 1'h0);
        cycles(30);
        check_bit(nack, 1'h0);
        rd(nfl_pkg::ADDR_OVER_STATUS);
        check_byte(d, 8'h02);
        wr(nfl_pkg::ADDR_RECORD_ENABLE, 8'h00);
        over_fault = 5'h00;
        check_bit(conversion, 1'h0);
    endtask : t_record
    task automatic t_clear();
        wr(nfl_pkg::ADDR_DATA_IN_HIGH, 8'h00);
        wr(nfl_pkg::ADDR_DATA_IN_LOW, 8'h00);
        for (int w = 0; w < 2; w++) begin
            wr(nfl_pkg::ADDR_NVM_TARGET, w == 0 ? nfl_pkg::ADDR_LOG_STATUS : 8'h84);
            wr(nfl_pkg::ADDR_NVM_CONTROL, 8'h10);
            check_bit(nack, 1'h1);
            rd(nfl_pkg::ADDR_NVM_CONTROL);
            check_byte(d, 8'h00);
        end
        rd(8'h8C);
        check_byte(d, 8'h00);
        rd(8'h8D);
        check_byte(d, 8'h00);
        rd(8'h84);
        check_byte(d, 8'h00);
        rd(8'h85);
        check_byte(d, 8'h00);
        rd(8'h82);
        check_byte(d, 8'h20);
    endtask : t_clear
    task automatic t_skip();
        diode_open = 5'h05;
        cycles(5);
        check_byte({3'h0, skip}, 8'h05);
    endtask : t_skip
    // Channel 0 is open here, so its new temperature must not reach the log.
    task automatic t_modes();
        temperature[0] = 16'h7F00;
        cont_mode = 1'h0;
        under_fault = 5'h02;
        sec_fault = 5'h08;
        wr(nfl_pkg::ADDR_RECORD_ENABLE, 8'hFF);
        cycles(4);
        check_bit(nack, 1'h0);
        check_bit(secondary_alarm_n_n, 1'h0);
        cont_mode = 1'h1;
        cycles(4);
        check_bit(nack, 1'h1);
        rd(8'h8D);
        check_byte(d, 8'h02);
        rd(8'h84);
        check_byte(d, 8'h21);
        rd(8'h82);
        check_byte(d, 8'h20);
        wr(nfl_pkg::ADDR_ALARM_MASK, 8'h08);
        cycles(4);
        check_bit(secondary_alarm_n_n, 1'h1);
        wr(nfl_pkg::ADDR_RECORD_ENABLE, 8'h00);
        under_fault = 5'h00;
        sec_fault = 5'h00;
    endtask : t_modes
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    // The tests need well under a thousand cycles, so four thousand means a hang.
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
    initial begin
        failures = 0;
        total_checks = 0;
        srst = 1'h1;
        band = 3'h0;
        over_fault = 5'h00;
        under_fault = 5'h00;
        sec_fault = 5'h00;
        cont_mode = 1'h1;
        diode_open = 5'h00;
        for (int k = 0; k < 8; k++) nvm_config[k] = 8'hA0 + 8'(k);
        for (int k = 0; k < 5; k++) temperature[k] = {8'h20 + 8'(k), 8'h40 + 8'(k)};
        cycles(20);
        srst = 1'h0;
        t_address();
        t_reload();
        t_record();
        t_clear();
        t_skip();
        t_modes();
        give_verdict();
    end
endmodule : tb_nfl_sequencer
`default_nettype wire
